/* File: rtl/io_port_pkg.sv */
/*
 * constants for the multipurpose port bank: register map, field layout,
 * reset values and reset sequencer timing.
 * assumes an APB master with 32-bit data and a 125 MHz pclk.
 */
package io_port_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [11:0] PORT_STRIDE     = 12'h010;
    localparam logic [1:0]  KIND_DIR        = 2'h0;
    localparam logic [1:0]  KIND_DATA       = 2'h1;
    localparam logic [1:0]  KIND_PULLUP     = 2'h2;
    localparam logic [1:0]  KIND_SELECT     = 2'h3;
    localparam logic [11:0] IRQ_CTRL_OFFSET = 12'h080;
    localparam logic [11:0] DRIVE_OFFSET    = 12'h0a0;
    localparam logic [11:0] PEN_OFFSET      = 12'h0a4;

    // ------------------------------------------------------------------
    // port roles
    // ------------------------------------------------------------------
    localparam int BUS_PORT      = 0;
    localparam int RETAIN_PORT_A = 1;
    localparam int RETAIN_PORT_B = 2;
    localparam int IRQ_PORT      = 3;
    localparam int IRQ_CTRL_REGS = 4;

    // ------------------------------------------------------------------
    // fields
    // ------------------------------------------------------------------
    localparam int PEN_POL_BIT = 0;
    localparam int PEN_EN_BIT  = 1;
    localparam int PEN_PIN_BIT = 8;
    localparam int PEN_IRQ_BIT = 9;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DIR_RST      = 8'h00;
    localparam logic [7:0] DATA_RST     = 8'h00;
    localparam logic [7:0] PULLUP_RST   = 8'hff;
    localparam logic [7:0] SELECT_RST   = 8'hff;
    localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
    localparam logic       DRIVE_RST    = 1'b1;
    localparam logic       PEN_POL_RST  = 1'b0;
    localparam logic       PEN_EN_RST   = 1'b1;
    localparam logic [2:0] PEN_LEVEL    = 3'h5;

    // ------------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------------
    localparam int PULSE_DELAY_CYCLES = 16;

    typedef enum logic [2:0] {
        S_RUN         = 3'b000,
        S_WAIT_ASSERT = 3'b001,
        S_IN_RESET    = 3'b011,
        S_WAIT_FALL   = 3'b010,
        S_COUNT       = 3'b110,
        S_PULSE       = 3'b111
    } rst_state_e;

endpackage

/* File: rtl/reset_sequencer.sv */
/*
 * warm reset sequencer: internal reset and its one-cycle closing pulse.
 * assumes ext_reset_n and slow_clk are synchronous to pclk.
 */
`timescale 1ns/1ns
`default_nettype none
module reset_sequencer
    import io_port_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ext_reset_n,
    input  wire logic slow_clk,
    output var  logic int_reset_r,
    output var  logic reset_pulse_r
);

    rst_state_e state_r;
    logic       slow_q_r;
    logic [4:0] cnt_r;
    logic       slow_fall;

    assign slow_fall = slow_q_r & ~slow_clk;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_q_r <= 1'b0;
        end else begin
            slow_q_r <= slow_clk;
        end
    end

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r       <= S_IN_RESET;
            int_reset_r   <= 1'b1;
            reset_pulse_r <= 1'b0;
            cnt_r         <= 5'h00;
        end else begin
            case (state_r)
                S_RUN: begin
                    if (!ext_reset_n) begin
                        state_r <= S_WAIT_ASSERT;
                    end
                end
                S_WAIT_ASSERT: begin
                    if (slow_fall) begin
                        state_r     <= S_IN_RESET;
                        int_reset_r <= 1'b1;
                    end
                end
                S_IN_RESET: begin
                    if (ext_reset_n) begin
                        state_r <= S_WAIT_FALL;
                    end
                end
                S_WAIT_FALL: begin
                    if (!ext_reset_n) begin
                        state_r <= S_IN_RESET;
                    end else if (slow_fall) begin
                        state_r <= S_COUNT;
                        cnt_r   <= 5'h00;
                    end
                end
                S_COUNT: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == 5'(PULSE_DELAY_CYCLES - 1)) begin
                        state_r       <= S_PULSE;
                        reset_pulse_r <= 1'b1;
                    end
                end
                S_PULSE: begin
                    state_r       <= S_RUN;
                    reset_pulse_r <= 1'b0;
                    int_reset_r   <= 1'b0;
                end
                default: begin
                    state_r <= S_IN_RESET;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence release_fall_s;
        state_r == S_WAIT_FALL && ext_reset_n && slow_fall;
    endsequence

    // seventeen quiet samples: the fall edge plus the sixteen counted cycles
    sequence quiet_count_s;
        !reset_pulse_r [*8] ##1 !reset_pulse_r [*8] ##1 !reset_pulse_r;
    endsequence

    sequence one_pulse_s;
        reset_pulse_r ##1 !reset_pulse_r;
    endsequence

    AST_ASSERT_ON_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == S_WAIT_ASSERT && slow_fall |=> int_reset_r)
        else $error("internal reset not asserted on slow clock fall");

    AST_PULSE_AFTER_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
        release_fall_s |-> quiet_count_s ##1 one_pulse_s)
        else $error("reset pulse not one cycle wide after 16 cycles");

endmodule
`default_nettype wire

/* File: rtl/io_port_bank.sv */
/*
 * multipurpose port bank: per-pin gpio or dedicated function mux,
 * port drive strength, pen interrupt input, warm reset retention.
 * assumes an APB master on pclk and pins synchronous to pclk.
 */
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - pen input is a level five interrupt source with a pull-up
// - pen interrupt fires on pen down or up, per polarity bit
// - each pin is configured on its own, but drive strength is set per port
// - a pin given to its module ignores software direction
// - each port has direction, data, pull-up and select registers
// - the first port has no select register
// - select bit picks gpio or the dedicated module per pin
// - the interrupt port has four extra interrupt control registers
// - all pins come out of reset at high drive strength
// - all ports but the first, DRAM ports included, have dedicated functions
// - on warm reset other ports take defaults for the whole reset
// - a port's default state is its registers' reset values
// - the two DRAM ports keep their setup during warm reset
// - internal reset asserts on first slow clock fall after external reset
// - the DRAM ports reset only when the closing pulse negates
// - after release, slow fall, 16 cycles, then a one-cycle pulse
// - on power-up the DRAM port pins stay undriven until the first closing pulse
// - gpio output drives data bit; data reads return the pin level
module io_port_bank
    import io_port_pkg::*;
#(
    parameter int NUM_PORTS = 6
)(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output var  logic [31:0]               prdata,
    output var  logic                      pready,
    output var  logic                      pslverr,
    input  wire logic                      ext_reset_n,
    input  wire logic                      slow_clk,
    input  wire logic [NUM_PORTS-1:0][7:0] pin_in,
    output var  logic [NUM_PORTS-1:0][7:0] pin_out,
    output var  logic [NUM_PORTS-1:0][7:0] pin_oe,
    output var  logic [NUM_PORTS-1:0][7:0] pin_pull_en,
    output var  logic [NUM_PORTS-1:0]      drive_high,
    input  wire logic [NUM_PORTS-1:0][7:0] mod_out,
    input  wire logic [NUM_PORTS-1:0][7:0] mod_oe,
    output var  logic [NUM_PORTS-1:0][7:0] mod_in,
    output var  logic [IRQ_CTRL_REGS-1:0][7:0] irq_ctrl,
    input  wire logic                      pen_interrupt_input,
    output var  logic                      pen_pullup_en,
    output var  logic                      pen_irq,
    output var  logic [2:0]                pen_irq_level,
    output var  logic                      core_reset,
    output var  logic                      core_reset_pulse
);

    logic [NUM_PORTS-1:0][7:0] dir_r;
    logic [NUM_PORTS-1:0][7:0] data_r;
    logic [NUM_PORTS-1:0][7:0] pullup_r;
    logic [NUM_PORTS-1:0][7:0] select_r;
    logic [NUM_PORTS-1:0]      drive_r;
    logic                      pen_polarity_bit;
    logic                      pen_en_r;
    logic                      retained_valid_r;
    logic                      int_reset;
    logic                      reset_pulse;
    logic                      setup;
    logic                      wr_en;
    logic [7:0]                rd_byte;
    logic                      rd_hit;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_retained(input int p);
        return (p == RETAIN_PORT_A) || (p == RETAIN_PORT_B);
    endfunction

    function automatic logic port_hit(input logic [11:0] a, input int p, input logic [1:0] k);
        return a == 12'(p * PORT_STRIDE) + 12'({k, 2'b00});
    endfunction

    function automatic logic irq_hit(input logic [11:0] a, input int k);
        return a == IRQ_CTRL_OFFSET + 12'(k * 4);
    endfunction

    // ------------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------------
    reset_sequencer u_seq (
        .pclk          (pclk),
        .presetn       (presetn),
        .ext_reset_n   (ext_reset_n),
        .slow_clk      (slow_clk),
        .int_reset_r   (int_reset),
        .reset_pulse_r (reset_pulse)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset       <= 1'b1;
            core_reset_pulse <= 1'b0;
        end else begin
            core_reset       <= int_reset;
            core_reset_pulse <= reset_pulse;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (port_hit(paddr, p, KIND_DIR)) begin
                rd_byte = dir_r[p];
                rd_hit  = 1'b1;
            end
            if (port_hit(paddr, p, KIND_DATA)) begin
                rd_byte = pin_in[p];
                rd_hit  = 1'b1;
            end
            if (port_hit(paddr, p, KIND_PULLUP)) begin
                rd_byte = pullup_r[p];
                rd_hit  = 1'b1;
            end
            if (p != BUS_PORT && port_hit(paddr, p, KIND_SELECT)) begin
                rd_byte = select_r[p];
                rd_hit  = 1'b1;
            end
        end
        for (int k = 0; k < IRQ_CTRL_REGS; k++) begin
            if (irq_hit(paddr, k)) begin
                rd_byte = irq_ctrl[k];
                rd_hit  = 1'b1;
            end
        end
        if (paddr == DRIVE_OFFSET) begin
            rd_byte = 8'(drive_r);
            rd_hit  = 1'b1;
        end
        if (paddr == PEN_OFFSET) begin
            rd_hit = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~rd_hit;
            if (setup && !pwrite && paddr == PEN_OFFSET) begin
                prdata <= 32'h0000_0000;
                prdata[PEN_POL_BIT] <= pen_polarity_bit;
                prdata[PEN_EN_BIT]  <= pen_en_r;
                prdata[PEN_PIN_BIT] <= pen_interrupt_input;
                prdata[PEN_IRQ_BIT] <= pen_irq;
            end else if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r    <= {NUM_PORTS{DIR_RST}};
            data_r   <= {NUM_PORTS{DATA_RST}};
            pullup_r <= {NUM_PORTS{PULLUP_RST}};
            select_r <= {NUM_PORTS{SELECT_RST}};
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if ((int_reset && !is_retained(p)) || (reset_pulse && is_retained(p))) begin
                    dir_r[p]    <= DIR_RST;
                    data_r[p]   <= DATA_RST;
                    pullup_r[p] <= PULLUP_RST;
                    select_r[p] <= SELECT_RST;
                end else if (wr_en) begin
                    if (port_hit(paddr, p, KIND_DIR)) begin
                        dir_r[p] <= pwdata[7:0];
                    end
                    if (port_hit(paddr, p, KIND_DATA)) begin
                        data_r[p] <= pwdata[7:0];
                    end
                    if (port_hit(paddr, p, KIND_PULLUP)) begin
                        pullup_r[p] <= pwdata[7:0];
                    end
                    if (p != BUS_PORT && port_hit(paddr, p, KIND_SELECT)) begin
                        select_r[p] <= pwdata[7:0];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // system registers: interrupt control, drive, pen
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ctrl         <= {IRQ_CTRL_REGS{IRQ_CTRL_RST}};
            drive_r          <= {NUM_PORTS{DRIVE_RST}};
            pen_polarity_bit <= PEN_POL_RST;
            pen_en_r         <= PEN_EN_RST;
        end else if (int_reset) begin
            irq_ctrl         <= {IRQ_CTRL_REGS{IRQ_CTRL_RST}};
            drive_r          <= {NUM_PORTS{DRIVE_RST}};
            pen_polarity_bit <= PEN_POL_RST;
            pen_en_r         <= PEN_EN_RST;
        end else if (wr_en) begin
            for (int k = 0; k < IRQ_CTRL_REGS; k++) begin
                if (irq_hit(paddr, k)) begin
                    irq_ctrl[k] <= pwdata[7:0];
                end
            end
            if (paddr == DRIVE_OFFSET) begin
                drive_r <= pwdata[NUM_PORTS-1:0];
            end
            if (paddr == PEN_OFFSET) begin
                pen_polarity_bit <= pwdata[PEN_POL_BIT];
                pen_en_r         <= pwdata[PEN_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // pen interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pen_irq       <= 1'b0;
            pen_pullup_en <= 1'b0;
            pen_irq_level <= 3'h0;
        end else begin
            pen_irq       <= pen_en_r & (pen_interrupt_input == pen_polarity_bit);
            pen_pullup_en <= 1'b1;
            pen_irq_level <= PEN_LEVEL;
        end
    end

    // ------------------------------------------------------------------
    // pin mux
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retained_valid_r <= 1'b0;
        end else if (reset_pulse) begin
            retained_valid_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out     <= '0;
            pin_oe      <= '0;
            pin_pull_en <= '0;
            mod_in      <= '0;
            drive_high  <= '0;
        end else begin
            drive_high  <= drive_r;
            pin_pull_en <= pullup_r;
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int b = 0; b < 8; b++) begin
                    if (p == BUS_PORT || select_r[p][b]) begin
                        pin_out[p][b] <= data_r[p][b];
                        pin_oe[p][b]  <= dir_r[p][b];
                        mod_in[p][b]  <= 1'b0;
                    end else begin
                        pin_out[p][b] <= mod_out[p][b];
                        pin_oe[p][b]  <= mod_oe[p][b];
                        mod_in[p][b]  <= pin_in[p][b];
                    end
                    if (is_retained(p) && !retained_valid_r) begin
                        pin_oe[p][b] <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_WARM_DEFAULTS: assert property (@(posedge pclk) disable iff (!presetn)
        int_reset |=> dir_r[IRQ_PORT] == DIR_RST && select_r[IRQ_PORT] == SELECT_RST)
        else $error("non-retained port left its default during reset");

    AST_RETAIN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        int_reset && !reset_pulse && retained_valid_r |=> $stable(dir_r[RETAIN_PORT_A]))
        else $error("retained port changed during reset");

    AST_RETAIN_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        reset_pulse |=> select_r[RETAIN_PORT_B] == SELECT_RST && retained_valid_r)
        else $error("retained port not reset by closing pulse");

    AST_GPIO_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
        select_r[IRQ_PORT][0] && dir_r[IRQ_PORT][0]
        |=> pin_oe[IRQ_PORT][0] && pin_out[IRQ_PORT][0] == $past(data_r[IRQ_PORT][0]))
        else $error("gpio output does not follow data bit");

    AST_MODULE_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        !select_r[IRQ_PORT][1] |=> pin_oe[IRQ_PORT][1] == $past(mod_oe[IRQ_PORT][1])
        && mod_in[IRQ_PORT][1] == $past(pin_in[IRQ_PORT][1]))
        else $error("module function not routed to pin");

    AST_DRIVE_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
        reset_pulse |=> ##1 drive_high == {NUM_PORTS{DRIVE_RST}})
        else $error("drive strength not high after reset");

    AST_PEN_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        pen_en_r && pen_interrupt_input == pen_polarity_bit |=> pen_irq && pen_irq_level == PEN_LEVEL)
        else $error("pen interrupt not raised");

    AST_DATA_READ: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == 12'h014 |=> prdata[7:0] == $past(pin_in[1]))
        else $error("data read does not return pin level");

    AST_SELECT_REFUSED: assert property (@(posedge pclk) disable iff (!presetn)
        setup && port_hit(paddr, BUS_PORT, KIND_SELECT) |=> pready && pslverr)
        else $error("first port select access not refused");

    AST_POWERUP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !retained_valid_r |=> pin_oe[RETAIN_PORT_A] == 8'h00 && pin_oe[RETAIN_PORT_B] == 8'h00)
        else $error("retained port driven before first closing pulse");

endmodule
`default_nettype wire

/* File: verification/pin_far.sv */
/* far-side pin model: resolves each pin from port drive, outside drive
   and pull-up. assumes per-bit enables from the port bank. */
`timescale 1ns/1ns
`default_nettype none
module pin_far #(parameter int N = 6) (
    input  wire logic              pclk,
    input  wire logic [N-1:0][7:0] pin_out,
    input  wire logic [N-1:0][7:0] pin_oe,
    input  wire logic [N-1:0][7:0] pin_pull_en,
    input  wire logic [N-1:0][7:0] ext_val,
    input  wire logic [N-1:0][7:0] ext_en,
    output var  logic [N-1:0][7:0] pin_in
);
    logic [N-1:0][7:0] last_r;
    always_ff @(posedge pclk) last_r <= pin_in;
    // floating bits toggle so a stale level never reads back
    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                       | (~pin_oe & ~ext_en & (pin_pull_en | ~last_r));
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
/* self-checking bench for the port bank.
   assumes APB on pclk and slow_clk driven as a plain input. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import io_port_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_reset_n, slow_clk;
    logic pen_interrupt_input, pen_pullup_en, pen_irq, core_reset, core_reset_pulse, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, d;
    logic [5:0][7:0] pin_in, pin_out, pin_oe, pin_pull_en, mod_out, mod_oe, mod_in, ext_val, ext_en;
    logic [5:0] drive_high;
    logic [3:0][7:0] irq_ctrl;
    logic [2:0] pen_irq_level;
    int n_errors = 0, tests_run = 0, cyc = 0, k;

    io_port_bank #(.NUM_PORTS(6)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_reset_n, .slow_clk, .pin_in, .pin_out, .pin_oe, .pin_pull_en,
        .drive_high, .mod_out, .mod_oe, .mod_in, .irq_ctrl, .pen_interrupt_input, .pen_pullup_en,
        .pen_irq, .pen_irq_level, .core_reset, .core_reset_pulse);
    pin_far #(.N(6)) far (.pclk, .pin_out, .pin_oe, .pin_pull_en, .ext_val, .ext_en, .pin_in);

    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [7:0] mux(logic [7:0] sel, logic [7:0] g, logic [7:0] m);
        return (sel & g) | (~sel & m);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic fall();
        slow_clk <= 1;
        repeat (3) @(posedge pclk);
        slow_clk <= 0;
    endtask

    task automatic release_rst();
        ext_reset_n <= 1;
        fall();
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (core_reset_pulse !== 1'b1 && k < 40);
        chk(k, PULSE_DELAY_CYCLES + 3);
        @(posedge pclk);
        chk(core_reset_pulse, 0);
        chk(core_reset, 0);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext_reset_n, ext_val, ext_en} = '0;
        slow_clk = 1;
        pen_interrupt_input = 1;
        d = $urandom(32'hec8f);
        mod_out <= 48'({$urandom, $urandom});
        mod_oe <= 48'({$urandom, $urandom});
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        chk(core_reset, 1);
        chk(pen_irq_level, 5);
        chk(pen_pullup_en, 1);
        chk(drive_high, 6'h3f);
        chk(pin_oe[1], 0);
        release_rst();
        for (int p = 0; p < 6; p++) begin
            apb(0, 12'(p * 16 + 8), 0);
            chk(r, 32'hff);
            apb(0, 12'(p * 16), 0);
            chk(r, 32'h0);
        end
        apb(0, 12'h014, 0);
        chk(r, 32'hff);
        apb(0, 12'h00c, 0);
        chk(e, 1);
        apb(0, 12'h01c, 0);
        chk({e, r}, 33'hff);
        d = $urandom;
        apb(1, 12'h040, 32'hff);
        apb(1, 12'h044, d);
        apb(1, 12'h04c, 32'h0f);
        apb(1, 12'h030, 32'h01);
        apb(1, 12'h03c, 32'hfd);
        repeat (3) @(posedge pclk);
        chk(pin_oe[3], mux(8'hfd, 8'h01, mod_oe[3]));
        chk(pin_oe[4], mux(8'h0f, 8'hff, mod_oe[4]));
        chk(pin_out[4] & pin_oe[4], mux(8'h0f, d[7:0], mod_out[4]) & pin_oe[4]);
        chk(mod_in[4], 8'hf0 & pin_in[4]);
        apb(0, 12'h044, 0);
        chk(r[3:0], d[3:0]);
        apb(1, 12'h048, 32'h0f);
        @(posedge pclk);
        chk(pin_pull_en[4], 8'h0f);
        apb(1, 12'h084, d);
        chk(irq_ctrl[1], d[7:0]);
        apb(1, 12'h0a0, 32'h15);
        repeat (2) @(posedge pclk);
        chk(drive_high, 6'h15);
        for (int i = 0; i < 4; i++) begin
            apb(1, PEN_OFFSET, 32'(2 + i[0]));
            pen_interrupt_input <= i[1];
            repeat (3) @(posedge pclk);
            chk(pen_irq, i[1] == i[0]);
        end
        apb(0, PEN_OFFSET, 0);
        chk(r, 32'h303);
        apb(1, 12'h010, 32'hff);
        ext_reset_n <= 0;
        fall();
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (core_reset !== 1'b1 && k < 20);
        apb(1, 12'h040, 32'hff);
        apb(0, 12'h040, 0);
        chk(r, 0);
        chk(pin_oe[4], 0);
        chk(drive_high, 6'h3f);
        chk(pin_oe[1], 8'hff);
        release_rst();
        repeat (3) @(posedge pclk);
        chk(pin_oe[1], 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
